/* File: logic/dmct_pkg.sv */
// Package for the dual-mode counter/timer block.
// Assumes a single 10 MHz system clock and no register bus.
package dmct_pkg;
    // -----------------------------------------------------------------
    // Mode field encodings
    // -----------------------------------------------------------------
    localparam logic [1:0] MODE_13BIT  = 2'h0; // 13-bit counter/timer
    localparam logic [1:0] MODE_16BIT  = 2'h1; // 16-bit counter/timer
    localparam logic [1:0] MODE_RELOAD = 2'h2; // 8-bit auto-reload
    localparam logic [1:0] MODE_SPLIT  = 2'h3; // split / stopped
    // -----------------------------------------------------------------
    // Counter layout and reset values
    // -----------------------------------------------------------------
    localparam int         LOW5_MSB    = 4;     // Top used bit in 13-bit mode
    localparam logic [7:0] CNT_RST     = 8'h00; // Count byte reset value
    localparam logic [7:0] BYTE_ONES   = 8'hff; // Byte all-ones value
    localparam logic [4:0] LOW5_ONES   = 5'h1f; // Five-bit all-ones value
    // -----------------------------------------------------------------
    // Prescaler divide ratios, indexed by prescale_select
    // -----------------------------------------------------------------
    localparam logic [5:0] PRE_DIV0    = 6'h0c; // Divide by 12
    localparam logic [5:0] PRE_DIV1    = 6'h04; // Divide by 4
    localparam logic [5:0] PRE_DIV2    = 6'h30; // Divide by 48
    localparam logic [5:0] PRE_DIV3    = 6'h08; // Divide by 8
endpackage

/* File: logic/dmct_top.sv */
// Two classic counter/timers A and B with split mode for timer A.
// Assumes all inputs but the event and gate pins synchronous to CLK_I; control bits held by software.
//
// What this block does
// - Mode 0 forms 13-bit count, five low bits
// - 13-bit wrap sets flag, interrupt if enabled
// - Count-select counts falling edges on event pin
// - Otherwise system clock or prescaled clock
// - Run and gate with polarity enable counting, except timer B while A is split
// - Run bit never clears or reloads count
// - Timer B mirrors timer A in modes 0-2
// - Mode 1 uses full 16 bits
// - Mode 2 reloads low byte from high
// - Split mode: low byte is timer A
// - Split high byte: internal clock, run B, flag B
// - Split: B ignores events, no flag, rate pulse
// - B in mode 3 stops
// - Flags cleared by software or vector acknowledge
`timescale 1ns/1ns
`default_nettype none
module dmct_top (
    input  wire logic                  CLK_I,            // System clock
    input  wire logic                  RSTN_I,           // Async reset, low
    input  wire logic                  RUN_A_I,          // Run bit A
    input  wire logic                  RUN_B_I,          // Run bit B
    input  wire logic                  GATED_RUN_A_I,    // Gate enable A
    input  wire logic                  GATED_RUN_B_I,    // Gate enable B
    input  wire logic                  COUNT_SEL_A_I,    // Event count A
    input  wire logic                  COUNT_SEL_B_I,    // Event count B
    input  wire logic                  SYSCLK_SEL_A_I,   // Sysclk select A
    input  wire logic                  SYSCLK_SEL_B_I,   // Sysclk select B
    input  wire logic [1:0]            MODE_A_I,         // Mode field A
    input  wire logic [1:0]            MODE_B_I,         // Mode field B
    input  wire logic [1:0]            PRESCALE_SELECT_I,// Prescaler choice
    input  wire logic                  GATE_POLARITY_A_I,// Active gate lvl A
    input  wire logic                  GATE_POLARITY_B_I,// Active gate lvl B
    input  wire logic                  IRQ_ENABLE_A_I,   // Int enable A
    input  wire logic                  IRQ_ENABLE_B_I,   // Int enable B
    input  wire logic                  EXT_GATE_IN_A_I,  // Gate pin A
    input  wire logic                  EXT_GATE_IN_B_I,  // Gate pin B
    input  wire logic                  EVENT_PIN_A_I,    // Event pin A
    input  wire logic                  EVENT_PIN_B_I,    // Event pin B
    input  wire logic                  CNT_WR_I,         // Count byte write
    input  wire logic [1:0]            CNT_WR_SEL_I,     // 0 AL,1 AH,2 BL,3 BH
    input  wire logic [7:0]            CNT_WR_DATA_I,    // Count write data
    input  wire logic                  FLAG_A_CLR_I,     // Software clear A
    input  wire logic                  FLAG_B_CLR_I,     // Software clear B
    input  wire logic                  VECTOR_A_I,       // Vector ack A
    input  wire logic                  VECTOR_B_I,       // Vector ack B
    output logic      [7:0]            CNT_A_LOW_BYTE_O, // Count A low
    output logic      [7:0]            CNT_A_HIGH_BYTE_O,// Count A high
    output logic      [7:0]            CNT_B_LOW_BYTE_O, // Count B low
    output logic      [7:0]            CNT_B_HIGH_BYTE_O,// Count B high
    output logic                       OVF_FLAG_A_O,     // Overflow flag A
    output logic                       OVF_FLAG_B_O,     // Overflow flag B
    output logic                       IRQ_A_O,          // Interrupt A
    output logic                       IRQ_B_O,          // Interrupt B
    output logic                       RATE_PULSE_B_O    // B overflow pulse
);
    import dmct_pkg::*;

    // -----------------------------------------------------------------
    // Helper functions
    // -----------------------------------------------------------------
    // Gate qualification, shared by both timers
    function automatic logic run_ok(input logic run, input logic gate,
                                    input logic pin, input logic pol);
        run_ok = run & (~gate | (pin == pol));
    endfunction

    // Divide ratio for the prescaler field
    function automatic logic [5:0] pre_div(input logic [1:0] sel);
        case (sel)
            2'h0:    pre_div = PRE_DIV0;
            2'h1:    pre_div = PRE_DIV1;
            2'h2:    pre_div = PRE_DIV2;
            default: pre_div = PRE_DIV3;
        endcase
    endfunction

    // -----------------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------------
    logic [3:0] sync1_r;   // First stage: event A/B, gate A/B
    logic [3:0] sync2_r;   // Second stage
    logic [1:0] evt_old_r; // Previous synced event levels

    // Two flops per input; only sync2 feeds logic
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sync1_r   <= 4'hf;
            sync2_r   <= 4'hf;
            evt_old_r <= 2'h3;
        end else begin
            sync1_r   <= {EXT_GATE_IN_B_I, EXT_GATE_IN_A_I,
                          EVENT_PIN_B_I, EVENT_PIN_A_I};
            sync2_r   <= sync1_r;
            evt_old_r <= sync2_r[1:0];
        end
    end

    // Falling edges from successive synced samples
    wire [1:0] evt_fall = evt_old_r & ~sync2_r[1:0];

    // -----------------------------------------------------------------
    // Prescaler: one-cycle enable pulse
    // -----------------------------------------------------------------
    logic [5:0] pre_cnt_r; // Prescale counter
    wire  [5:0] pre_last = pre_div(PRESCALE_SELECT_I) - 6'h01;
    wire        pre_tick = (pre_cnt_r >= pre_last);

    // Wraps at the selected ratio; a ratio change takes effect at once
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pre_cnt_r <= 6'h00;
        end else if (pre_tick) begin
            pre_cnt_r <= 6'h00;
        end else begin
            pre_cnt_r <= pre_cnt_r + 6'h01;
        end
    end

    // -----------------------------------------------------------------
    // Tick and enable decode
    // -----------------------------------------------------------------
    wire split    = (MODE_A_I == MODE_SPLIT);
    wire int_a    = SYSCLK_SEL_A_I | pre_tick;
    wire int_b    = SYSCLK_SEL_B_I | pre_tick;
    // Timer A low part: events or internal clock
    wire tick_a   = COUNT_SEL_A_I ? evt_fall[0] : int_a;
    // Split high byte: internal clock only, run B, no gate
    wire tick_ah  = int_a;
    // Timer B: no external events while A is split
    wire tick_b   = (COUNT_SEL_B_I && !split) ? evt_fall[1] : int_b;
    wire en_a     = run_ok(RUN_A_I, GATED_RUN_A_I, sync2_r[2],
                           GATE_POLARITY_A_I) & tick_a;
    wire en_ah    = RUN_B_I & tick_ah & split;
    // While A is split, B runs by its mode alone
    wire run_b_ok = split ? 1'b1
                  : run_ok(RUN_B_I, GATED_RUN_B_I, sync2_r[3],
                           GATE_POLARITY_B_I);
    wire en_b     = run_b_ok & tick_b
                  & (MODE_B_I != MODE_SPLIT);

    // -----------------------------------------------------------------
    // Counters
    // -----------------------------------------------------------------
    logic [7:0] al_r, ah_r, bl_r, bh_r; // Count bytes
    logic [7:0] al_nxt, ah_nxt, bl_nxt, bh_nxt;
    logic       ovf_a, ovf_ah, ovf_b;   // One-cycle wrap strobes

    // Next-count logic for timer A (modes 0-3)
    always_comb begin
        al_nxt = al_r;
        ah_nxt = ah_r;
        ovf_a  = 1'b0;
        ovf_ah = 1'b0;
        case (MODE_A_I)
            MODE_13BIT: if (en_a) begin
                // Upper three low bits are don't-care; kept as zero
                al_nxt = {3'h0, al_r[LOW5_MSB:0] + 5'h01};
                if (al_r[LOW5_MSB:0] == LOW5_ONES) begin
                    ah_nxt = ah_r + 8'h01;
                    ovf_a  = (ah_r == BYTE_ONES);
                end
            end
            MODE_16BIT: if (en_a) begin
                al_nxt = al_r + 8'h01;
                if (al_r == BYTE_ONES) begin
                    ah_nxt = ah_r + 8'h01;
                    ovf_a  = (ah_r == BYTE_ONES);
                end
            end
            MODE_RELOAD: if (en_a) begin
                ovf_a  = (al_r == BYTE_ONES);
                al_nxt = ovf_a ? ah_r : al_r + 8'h01;
            end
            default: begin
                if (en_a) begin
                    al_nxt = al_r + 8'h01;
                    ovf_a  = (al_r == BYTE_ONES);
                end
                if (en_ah) begin
                    ah_nxt = ah_r + 8'h01;
                    ovf_ah = (ah_r == BYTE_ONES);
                end
            end
        endcase
    end

    // Next-count logic for timer B (mode 3 holds)
    always_comb begin
        bl_nxt = bl_r;
        bh_nxt = bh_r;
        ovf_b  = 1'b0;
        case (MODE_B_I)
            MODE_13BIT: if (en_b) begin
                bl_nxt = {3'h0, bl_r[LOW5_MSB:0] + 5'h01};
                if (bl_r[LOW5_MSB:0] == LOW5_ONES) begin
                    bh_nxt = bh_r + 8'h01;
                    ovf_b  = (bh_r == BYTE_ONES);
                end
            end
            MODE_16BIT: if (en_b) begin
                bl_nxt = bl_r + 8'h01;
                if (bl_r == BYTE_ONES) begin
                    bh_nxt = bh_r + 8'h01;
                    ovf_b  = (bh_r == BYTE_ONES);
                end
            end
            MODE_RELOAD: if (en_b) begin
                ovf_b  = (bl_r == BYTE_ONES);
                bl_nxt = ovf_b ? bh_r : bl_r + 8'h01;
            end
            default: begin
                bl_nxt = bl_r;
            end
        endcase
    end

    // Count registers; software writes take priority over counting.
    // Run bit has no path here, so enabling never disturbs the count.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            al_r <= CNT_RST;
            ah_r <= CNT_RST;
            bl_r <= CNT_RST;
            bh_r <= CNT_RST;
        end else begin
            al_r <= (CNT_WR_I && CNT_WR_SEL_I == 2'h0) ? CNT_WR_DATA_I
                                                       : al_nxt;
            ah_r <= (CNT_WR_I && CNT_WR_SEL_I == 2'h1) ? CNT_WR_DATA_I
                                                       : ah_nxt;
            bl_r <= (CNT_WR_I && CNT_WR_SEL_I == 2'h2) ? CNT_WR_DATA_I
                                                       : bl_nxt;
            bh_r <= (CNT_WR_I && CNT_WR_SEL_I == 2'h3) ? CNT_WR_DATA_I
                                                       : bh_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Flags and rate pulse
    // -----------------------------------------------------------------
    logic flag_a_r, flag_b_r, rate_b_r;
    // In split mode B's own overflow drives only the rate pulse
    wire  set_a = ovf_a;
    wire  set_b = split ? ovf_ah : ovf_b;

    // Set wins over a clear in the same cycle
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            flag_a_r <= 1'b0;
            flag_b_r <= 1'b0;
            rate_b_r <= 1'b0;
        end else begin
            flag_a_r <= set_a | (flag_a_r & ~FLAG_A_CLR_I
                                          & ~VECTOR_A_I);
            flag_b_r <= set_b | (flag_b_r & ~FLAG_B_CLR_I
                                          & ~VECTOR_B_I);
            rate_b_r <= ovf_b;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign CNT_A_LOW_BYTE_O  = al_r;
    assign CNT_A_HIGH_BYTE_O = ah_r;
    assign CNT_B_LOW_BYTE_O  = bl_r;
    assign CNT_B_HIGH_BYTE_O = bh_r;
    assign OVF_FLAG_A_O      = flag_a_r;
    assign OVF_FLAG_B_O      = flag_b_r;
    assign IRQ_A_O           = flag_a_r & IRQ_ENABLE_A_I;
    assign IRQ_B_O           = flag_b_r & IRQ_ENABLE_B_I;
    assign RATE_PULSE_B_O    = rate_b_r;
endmodule
`default_nettype wire

/* File: verif/dmct_checker.sv */
// Port-level assertions for the dual counter/timer top level.
// Sees only top ports; bound into every dmct_top below the module.
`timescale 1ns/1ns
`default_nettype none
module dmct_checker (
    input wire logic       CLK_I,             // System clock
    input wire logic       RSTN_I,            // Async reset, low
    input wire logic       RUN_A_I,           // Run bit A
    input wire logic       GATED_RUN_A_I,     // Gate enable A
    input wire logic       COUNT_SEL_A_I,     // Event count A
    input wire logic       SYSCLK_SEL_A_I,    // Sysclk select A
    input wire logic [1:0] MODE_A_I,          // Mode field A
    input wire logic [1:0] MODE_B_I,          // Mode field B
    input wire logic       IRQ_ENABLE_A_I,    // Int enable A
    input wire logic       IRQ_ENABLE_B_I,    // Int enable B
    input wire logic       CNT_WR_I,          // Count byte write
    input wire logic [7:0] CNT_A_LOW_BYTE_O,  // Count A low
    input wire logic [7:0] CNT_A_HIGH_BYTE_O, // Count A high
    input wire logic [7:0] CNT_B_LOW_BYTE_O,  // Count B low
    input wire logic [7:0] CNT_B_HIGH_BYTE_O, // Count B high
    input wire logic       OVF_FLAG_A_O,      // Overflow flag A
    input wire logic       OVF_FLAG_B_O,      // Overflow flag B
    input wire logic       IRQ_A_O,           // Interrupt A
    input wire logic       IRQ_B_O            // Interrupt B
);
    import dmct_pkg::*;
    // ---------------------------------------------------------------
    // Helpers: timer A free-running on sysclk, no write in flight
    // ---------------------------------------------------------------
    wire logic        free_a;  // Writes excluded: they beat counting
    wire logic [15:0] cnt_a;   // Both A bytes as one value
    assign free_a = RUN_A_I && !GATED_RUN_A_I && !COUNT_SEL_A_I
                    && SYSCLK_SEL_A_I && !CNT_WR_I;
    assign cnt_a = {CNT_A_HIGH_BYTE_O, CNT_A_LOW_BYTE_O};
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    AST_IRQ_A: assert property (IRQ_A_O == (OVF_FLAG_A_O && IRQ_ENABLE_A_I))
        else $error("irq a not flag and enable");
    AST_IRQ_B: assert property (IRQ_B_O == (OVF_FLAG_B_O && IRQ_ENABLE_B_I))
        else $error("irq b not flag and enable");
    AST_HOLD_A: assert property (!RUN_A_I && !CNT_WR_I |=>
        $stable(CNT_A_LOW_BYTE_O)) else $error("a counts while off");
    AST_STEP16_A: assert property (free_a && MODE_A_I == MODE_16BIT &&
        cnt_a != 16'hffff |=> cnt_a == 16'($past(cnt_a) + 16'h0001))
        else $error("a 16 bit step wrong");
    AST_WRAP16_A: assert property (free_a && MODE_A_I == MODE_16BIT &&
        cnt_a == 16'hffff |=> cnt_a == 16'h0000 ##1 OVF_FLAG_A_O)
        else $error("a 16 bit wrap wrong");
    AST_CARRY13_A: assert property (free_a && MODE_A_I == MODE_13BIT &&
        CNT_A_LOW_BYTE_O[4:0] == LOW5_ONES |=> CNT_A_LOW_BYTE_O[4:0] ==
        5'h00 && CNT_A_HIGH_BYTE_O == 8'($past(CNT_A_HIGH_BYTE_O) + 8'h01))
        else $error("a 13 bit carry wrong");
    AST_RELOAD_A: assert property (free_a && MODE_A_I == MODE_RELOAD &&
        CNT_A_LOW_BYTE_O == BYTE_ONES |=> CNT_A_LOW_BYTE_O ==
        $past(CNT_A_HIGH_BYTE_O) && $stable(CNT_A_HIGH_BYTE_O))
        else $error("a reload wrong");
    AST_STOP_B: assert property (MODE_B_I == MODE_SPLIT && MODE_A_I !=
        MODE_SPLIT && !CNT_WR_I |=> $stable(CNT_B_LOW_BYTE_O) &&
        $stable(CNT_B_HIGH_BYTE_O)) else $error("b counts in mode 3");
    // Main scenarios reached
    cover property (free_a && cnt_a == 16'hffff);
    cover property ($rose(OVF_FLAG_B_O));
    cover property ($rose(IRQ_A_O));
endmodule
bind dmct_top dmct_checker u_dmct_checker (.CLK_I(CLK_I), .RSTN_I(RSTN_I),
    .RUN_A_I(RUN_A_I), .GATED_RUN_A_I(GATED_RUN_A_I),
    .COUNT_SEL_A_I(COUNT_SEL_A_I), .SYSCLK_SEL_A_I(SYSCLK_SEL_A_I),
    .MODE_A_I(MODE_A_I), .MODE_B_I(MODE_B_I),
    .IRQ_ENABLE_A_I(IRQ_ENABLE_A_I), .IRQ_ENABLE_B_I(IRQ_ENABLE_B_I),
    .CNT_WR_I(CNT_WR_I), .CNT_A_LOW_BYTE_O(CNT_A_LOW_BYTE_O),
    .CNT_A_HIGH_BYTE_O(CNT_A_HIGH_BYTE_O),
    .CNT_B_LOW_BYTE_O(CNT_B_LOW_BYTE_O),
    .CNT_B_HIGH_BYTE_O(CNT_B_HIGH_BYTE_O), .OVF_FLAG_A_O(OVF_FLAG_A_O),
    .OVF_FLAG_B_O(OVF_FLAG_B_O), .IRQ_A_O(IRQ_A_O), .IRQ_B_O(IRQ_B_O));
`default_nettype wire

/* File: verif/dmct_pin_model.sv */
// Model of the pins outside the counter block: event and gate lines.
// Driven through its tasks; every change lands on a falling clock edge.
`timescale 1ns/1ns
`default_nettype none
module dmct_pin_model (
    input  wire logic clk_i,    // System clock
    output logic      ev_a_o,   // Event source A
    output logic      ev_b_o,   // Event source B, kept idle
    output logic      gate_a_o, // Gate line A
    output logic      gate_b_o  // Gate line B, kept inactive
);
    // Events idle high: a low idle would look like one edge at start
    initial begin
        ev_a_o = 1'b1;
        ev_b_o = 1'b1;
        gate_a_o = 1'b0;
        gate_b_o = 1'b0;
    end
    // Gate level change
    task automatic set_gate_a(input logic v);
        @(negedge clk_i);
        gate_a_o = v;
    endtask
    // Each level held three clocks, period six: under a quarter rate
    task automatic pulse_a(input int n);
        repeat (n) begin
            @(negedge clk_i);
            ev_a_o = 1'b0;
            repeat (3) @(negedge clk_i);
            ev_a_o = 1'b1;
            repeat (2) @(negedge clk_i);
        end
        repeat (6) @(negedge clk_i); // Let the sync pipeline drain
    endtask
endmodule
`default_nettype wire

/* File: verif/dmct_tb_top.sv */
// Self-checking bench for the dual counter/timer top level.
// Assumes the package, design, checker and pin model compile first.
`timescale 1ns/1ns
`default_nettype none
module dmct_tb_top;
    import dmct_pkg::*;
    logic clk, rstn, run_a, run_b, gt_a, gt_b, cs_a, cs_b, ss_a, ss_b;
    logic pol_a, pol_b, ie_a, ie_b, wr, clr_a, clr_b, vec_a, vec_b;
    logic [1:0] mode_a, mode_b, ps, wsel;
    logic [7:0] wdat, al, ah, bl, bh;
    logic ev_a, ev_b, gi_a, gi_b, fa, fb, ia, ib, rp;
    int failures, n_compared;
    dmct_top u_dmct_top (.CLK_I(clk), .RSTN_I(rstn), .RUN_A_I(run_a),
        .RUN_B_I(run_b), .GATED_RUN_A_I(gt_a), .GATED_RUN_B_I(gt_b),
        .COUNT_SEL_A_I(cs_a), .COUNT_SEL_B_I(cs_b), .SYSCLK_SEL_A_I(ss_a),
        .SYSCLK_SEL_B_I(ss_b), .MODE_A_I(mode_a), .MODE_B_I(mode_b),
        .PRESCALE_SELECT_I(ps), .GATE_POLARITY_A_I(pol_a),
        .GATE_POLARITY_B_I(pol_b), .IRQ_ENABLE_A_I(ie_a),
        .IRQ_ENABLE_B_I(ie_b), .EXT_GATE_IN_A_I(gi_a),
        .EXT_GATE_IN_B_I(gi_b), .EVENT_PIN_A_I(ev_a), .EVENT_PIN_B_I(ev_b),
        .CNT_WR_I(wr), .CNT_WR_SEL_I(wsel), .CNT_WR_DATA_I(wdat),
        .FLAG_A_CLR_I(clr_a), .FLAG_B_CLR_I(clr_b), .VECTOR_A_I(vec_a),
        .VECTOR_B_I(vec_b), .CNT_A_LOW_BYTE_O(al), .CNT_A_HIGH_BYTE_O(ah),
        .CNT_B_LOW_BYTE_O(bl), .CNT_B_HIGH_BYTE_O(bh), .OVF_FLAG_A_O(fa),
        .OVF_FLAG_B_O(fb), .IRQ_A_O(ia), .IRQ_B_O(ib), .RATE_PULSE_B_O(rp));
    dmct_pin_model u_dmct_pin_model (.clk_i(clk), .ev_a_o(ev_a),
        .ev_b_o(ev_b), .gate_a_o(gi_a), .gate_b_o(gi_b));
    always #50 clk = ~clk; // 10 MHz
    // Helpers: exact and ranged compares, waits, byte writes
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [15:0] got, input int lo, hi);
        n_compared++;
        if (^got === 1'bx || got < lo || got > hi) begin
            failures++;
            $display("wrong value at %0t: got %h not in range", $time, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr8(input logic [1:0] s, input logic [7:0] d);
        @(negedge clk);
        wsel = s;
        wdat = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    // Scenarios
    task automatic t_mode0();
        {mode_a, ss_a} = {MODE_13BIT, 1'b1};
        wr8(2'h0, 8'h1f);
        wr8(2'h1, 8'h07);
        cyc(2);
        chk({ah, al}, 16'h071f);
        run_a = 1'b1;
        cyc(1);
        run_a = 1'b0;
        chk({ah, al}, 16'h0800);
        $display("mode 0 carry done");
    endtask
    task automatic t_mode1();
        {mode_a, ie_a} = {MODE_16BIT, 1'b1};
        wr8(2'h0, 8'hfe);
        wr8(2'h1, 8'hff);
        run_a = 1'b1;
        cyc(2);
        run_a = 1'b0;
        chk({ah, al}, 16'h0000);
        cyc(1);
        chk({fa, ia}, 16'h0003);
        ie_a = 1'b0;
        cyc(1);
        chk(ia, 16'h0000);
        clr_a = 1'b1;
        cyc(1);
        clr_a = 1'b0;
        chk(fa, 16'h0000);
        $display("mode 1 wrap done");
    endtask
    task automatic t_reload();
        mode_a = MODE_RELOAD;
        wr8(2'h1, 8'hfd);
        wr8(2'h0, 8'hfe);
        run_a = 1'b1;
        cyc(2);
        run_a = 1'b0;
        chk({ah, al}, 16'hfdfd);
        cyc(1);
        chk(fa, 16'h0001);
        vec_a = 1'b1;
        cyc(1);
        vec_a = 1'b0;
        chk(fa, 16'h0000);
        $display("mode 2 reload done");
    endtask
    task automatic t_events();
        {mode_a, cs_a, gt_a, pol_a} = {MODE_16BIT, 3'b111};
        wr8(2'h0, 8'h00);
        wr8(2'h1, 8'h00);
        run_a = 1'b1;
        u_dmct_pin_model.pulse_a(2);
        chk({ah, al}, 16'h0000);
        u_dmct_pin_model.set_gate_a(1'b1);
        cyc(4);
        u_dmct_pin_model.pulse_a(3);
        chk({ah, al}, 16'h0003);
        pol_a = 1'b0;
        u_dmct_pin_model.pulse_a(1);
        chk({ah, al}, 16'h0003);
        {run_a, cs_a, gt_a} = 3'b000;
        $display("event count and gate done");
    endtask
    task automatic t_split();
        {mode_a, mode_b, ss_b, ie_b} = {MODE_SPLIT, MODE_16BIT, 2'b11};
        wr8(2'h1, 8'hff);
        wr8(2'h0, 8'h40);
        run_b = 1'b1;
        cyc(1);
        run_b = 1'b0;
        chk({ah, al}, 16'h0040);
        cyc(1);
        chk({fb, ib}, 16'h0003);
        clr_b = 1'b1;
        cyc(1);
        clr_b = 1'b0;
        // B free-runs while A is split: its wrap gives only the rate pulse
        wr8(2'h3, 8'hff);
        wr8(2'h2, 8'hff);
        cyc(1);
        chk({rp, fb}, 16'h0002);
        cyc(1);
        chk(rp, 16'h0000);
        // Split low byte of A counts under run A alone
        run_a = 1'b1;
        cyc(2);
        run_a = 1'b0;
        chk({ah, al}, 16'h0042);
        {mode_a, mode_b} = {MODE_16BIT, MODE_SPLIT};
        cyc(3);
        chk(fb, 16'h0000);
        $display("split mode done");
    endtask
    task automatic t_prescale();
        logic [5:0] divs[4];
        divs = '{PRE_DIV0, PRE_DIV1, PRE_DIV2, PRE_DIV3};
        {mode_b, ss_b} = {MODE_16BIT, 1'b0};
        for (int i = 0; i < 4; i++) begin
            ps = 2'(i);
            wr8(2'h2, 8'h00);
            wr8(2'h3, 8'h00);
            run_b = 1'b1;
            cyc(int'(divs[i]) * 4);
            run_b = 1'b0;
            chk_rng({bh, bl}, 3, 5);
        end
        $display("prescaler on timer b done");
    endtask
    task automatic print_verdict();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog: all scenarios need well under 2000 clocks
    initial begin
        #500000;
        failures++;
        print_verdict();
    end
    // Main sequence
    initial begin
        {clk, rstn, run_a, run_b, gt_a, gt_b, cs_a, cs_b, ss_a, ss_b} = '0;
        {pol_a, pol_b, ie_a, ie_b, wr, clr_a, clr_b, vec_a, vec_b} = '0;
        {mode_a, mode_b, ps, wsel, wdat} = '0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        t_mode0();
        t_mode1();
        t_reload();
        t_events();
        t_split();
        t_prescale();
        print_verdict();
    end
endmodule
`default_nettype wire
